// [rtl/sfpf_pkg.sv]
// Constants and types for the serial flash pin front end
package sfpf_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ             = 250;
  localparam int RESET_PULSE_MIN_NS  = 1000;
  localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_RECOVERY_NS   = 28000;
  localparam int RESET_RECOVERY_CYC  = (RESET_RECOVERY_NS * CLK_MHZ) / 1000;

  // ----------------------------------------
  // Transfer sizes and reset values
  // ----------------------------------------
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [8:0] PAGE_MAX_BYTES = 9'h100;
  localparam logic [1:0] DUMMY_SD_DEF   = 2'h1;
  localparam logic [1:0] DUMMY_QUAD_DEF = 2'h3;
  localparam logic [7:0] TX_IDLE_BYTE   = 8'hFF;
  localparam logic [3:0] LANE_SYNC_RST  = 4'hC;
  localparam logic [3:0] OE_SINGLE      = 4'h2;
  localparam logic [3:0] OE_DUAL        = 4'h3;
  localparam logic [3:0] OE_QUAD        = 4'hF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} sfpf_lane_t;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_DUMMY, ST_DRIVE, ST_RST_HOLD, ST_RECOVER} sfpf_state_t;

endpackage

// [rtl/sfpf_front_end.sv]
// Pin-level front end of a serial NOR flash: lanes, select, pause/reset, write-protect
`timescale 1ns/1ps

module sfpf_front_end
  import sfpf_pkg::*;
#(
  parameter int RECOVERY_CYC = RESET_RECOVERY_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       serial_clk,
  input  wire logic       chip_sel_n,
  input  wire logic       io_lane_0_in,
  output logic            io_lane_0_out,
  output logic            io_lane_0_oe,
  input  wire logic       io_lane_1_in,
  output logic            io_lane_1_out,
  output logic            io_lane_1_oe,
  input  wire logic       io_lane_2_in,
  output logic            io_lane_2_out,
  output logic            io_lane_2_oe,
  input  wire logic       io_lane_3_in,
  output logic            io_lane_3_out,
  output logic            io_lane_3_oe,
  input  wire sfpf_lane_t lane_mode,
  input  wire logic       pin_function_disable,
  input  wire logic       pause_or_reset_select,
  input  wire logic       status_reg_lock,
  input  wire logic [3:0] block_guard_bits,
  input  wire logic       dummy_cfg_en,
  input  wire logic [1:0] dummy_cfg,
  input  wire logic       page_program_active,
  input  wire logic       turnaround_req,
  output logic [7:0]      rx_data,
  output logic            rx_first,
  output logic            rx_page_over,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            rx_overrun,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            frame_active,
  output logic            device_reset,
  output logic            status_write_ok,
  output logic            array_guarded
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [3:0]  lane_s1;
    logic [3:0]  lane_s2;
    sfpf_state_t st;
    logic        seen_high;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_bits;
    logic        first;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_bits;
    logic [1:0]  dummy_left;
    logic [7:0]  low_cnt;
    logic [15:0] tmr;
    logic [8:0]  page_cnt;
    logic [9:0]  buf0;
    logic [9:0]  buf1;
    logic        v0;
    logic        v1;
    logic        overrun;
    logic [3:0]  lane_o;
    logic [3:0]  lane_oe;
    logic        tx_rdy;
    logic        frame;
    logic        dev_rst;
    logic        sw_ok;
    logic        guarded;
  } sfpf_regs_t;

  sfpf_regs_t r_q;
  sfpf_regs_t r_d;

  // ----------------------------------------
  // Lane helpers
  // ----------------------------------------
  function automatic logic [3:0] lane_step(input sfpf_lane_t m);
    case (m)
      LANE_DUAL: lane_step = 4'h2;
      LANE_QUAD: lane_step = 4'h4;
      default:   lane_step = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] ln,
                                          input sfpf_lane_t m);
    case (m)
      LANE_DUAL: shift_in = {sh[5:0], ln[1], ln[0]};
      LANE_QUAD: shift_in = {sh[3:0], ln};
      default:   shift_in = {sh[6:0], ln[0]};
    endcase
  endfunction

  function automatic logic [3:0] drive_bits(input logic [7:0] b, input sfpf_lane_t m);
    case (m)
      LANE_DUAL: drive_bits = {2'h0, b[7], b[6]};
      LANE_QUAD: drive_bits = b[7:4];
      default:   drive_bits = {2'h0, b[7], 1'h0};
    endcase
  endfunction

  function automatic logic [3:0] lane_oe_of(input sfpf_lane_t m);
    case (m)
      LANE_DUAL: lane_oe_of = OE_DUAL;
      LANE_QUAD: lane_oe_of = OE_QUAD;
      default:   lane_oe_of = OE_SINGLE;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_low;
  logic       cs_fall;
  logic       quad;
  logic       shared_pause;
  logic       shared_reset;
  logic       paused;
  logic [3:0] step;
  logic [3:0] nbits;
  logic       byte_done;
  logic [1:0] dummy_cnt;
  logic       pop;
  logic       push;
  logic [9:0] entry;
  logic [7:0] tx_byte;

  always_comb begin
    r_d = r_q;
    // Two flops ahead of any logic for every pin
    r_d.sclk_s  = {r_q.sclk_s[1:0], serial_clk};
    r_d.cs_s    = {r_q.cs_s[1:0], chip_sel_n};
    r_d.lane_s1 = {io_lane_3_in, io_lane_2_in, io_lane_1_in, io_lane_0_in};
    r_d.lane_s2 = r_q.lane_s1;
    r_d.tx_rdy  = 1'b0;

    sclk_rise = r_q.sclk_s[1] & ~r_q.sclk_s[2];
    sclk_fall = ~r_q.sclk_s[1] & r_q.sclk_s[2];
    cs_low    = ~r_q.cs_s[1];
    cs_fall   = ~r_q.cs_s[1] & r_q.cs_s[2];
    quad         = (lane_mode == LANE_QUAD);
    shared_pause = ~quad & ~pin_function_disable & ~pause_or_reset_select;
    shared_reset = ~quad & ~pin_function_disable & pause_or_reset_select;
    paused       = shared_pause & cs_low & ~r_q.lane_s2[3];

    step      = lane_step(lane_mode);
    nbits     = r_q.rx_bits + step;
    byte_done = sclk_rise & ~paused & (nbits == BYTE_BITS);
    dummy_cnt = dummy_cfg_en ? dummy_cfg : (quad ? DUMMY_QUAD_DEF : DUMMY_SD_DEF);
    tx_byte   = tx_valid ? tx_data : TX_IDLE_BYTE;

    r_d.sw_ok   = ~(~quad & ~r_q.lane_s2[2] & status_reg_lock);
    r_d.guarded = ~quad & ~r_q.lane_s2[2] & status_reg_lock & (block_guard_bits != 4'h0);

    // a high select must be seen first
    if (~cs_low) begin
      r_d.seen_high = 1'b1;
    end

    push  = 1'b0;
    entry = {r_q.first, 1'b0, shift_in(r_q.rx_sh, r_q.lane_s2, lane_mode)};

    if (shared_reset & ~r_q.lane_s2[3]) begin
      if (r_q.low_cnt != 8'(RESET_PULSE_MIN_CYC)) begin
        r_d.low_cnt = r_q.low_cnt + 8'h1;
      end
    end else begin
      r_d.low_cnt = 8'h0;
    end

    case (r_q.st)
      ST_IDLE: begin
        if (cs_fall & r_q.seen_high) begin
          r_d.st       = ST_RX;
          r_d.rx_bits  = 4'h0;
          r_d.first    = 1'b1;
          r_d.page_cnt = 9'h0;
          r_d.overrun  = 1'b0;
        end
      end
      ST_RX: begin
        if (sclk_rise & ~paused) begin
          r_d.rx_sh   = shift_in(r_q.rx_sh, r_q.lane_s2, lane_mode);
          r_d.rx_bits = byte_done ? 4'h0 : nbits;
        end
        if (byte_done) begin
          push      = 1'b1;
          r_d.first = 1'b0;
          // bytes past one page are flagged
          if (page_program_active & ~r_q.first) begin
            if (r_q.page_cnt == PAGE_MAX_BYTES) begin
              entry[8] = 1'b1;
            end else begin
              r_d.page_cnt = r_q.page_cnt + 9'h1;
            end
          end
        end
        if (turnaround_req) begin
          r_d.rx_bits    = 4'h0;
          r_d.tx_bits    = 4'h0;
          r_d.dummy_left = dummy_cnt;
          r_d.st         = (dummy_cnt == 2'h0) ? ST_DRIVE : ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (sclk_rise & ~paused) begin
          r_d.rx_bits = byte_done ? 4'h0 : nbits;
        end
        if (byte_done) begin
          r_d.dummy_left = r_q.dummy_left - 2'h1;
          if (r_q.dummy_left == 2'h1) begin
            r_d.st = ST_DRIVE;
          end
        end
      end
      ST_DRIVE: begin
        if (sclk_fall & ~paused) begin
          if (r_q.tx_bits == 4'h0) begin
            r_d.lane_o  = drive_bits(tx_byte, lane_mode);
            r_d.tx_sh   = tx_byte << step;
            r_d.tx_bits = BYTE_BITS - step;
            r_d.tx_rdy  = tx_valid;
          end else begin
            r_d.lane_o  = drive_bits(r_q.tx_sh, lane_mode);
            r_d.tx_sh   = r_q.tx_sh << step;
            r_d.tx_bits = r_q.tx_bits - step;
          end
        end
      end
      ST_RST_HOLD: begin
        if (r_q.lane_s2[3] | ~shared_reset) begin
          r_d.st  = ST_RECOVER;
          r_d.tmr = 16'h0;
        end
      end
      ST_RECOVER: begin
        if (r_q.tmr == 16'(RECOVERY_CYC - 1)) begin
          r_d.st = ST_IDLE;
        end else begin
          r_d.tmr = r_q.tmr + 16'h1;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase

    if (~cs_low & (r_q.st == ST_RX || r_q.st == ST_DUMMY || r_q.st == ST_DRIVE)) begin
      r_d.st = ST_IDLE;
    end

    if (r_q.low_cnt == 8'(RESET_PULSE_MIN_CYC) && r_q.st != ST_RECOVER) begin
      r_d.st        = ST_RST_HOLD;
      r_d.seen_high = 1'b0;
      r_d.v0        = 1'b0;
      r_d.v1        = 1'b0;
      r_d.overrun   = 1'b0;
      push          = 1'b0;
    end

    // Two-entry receive buffer; pin clock cannot stall, so slack absorbs one byte
    pop = r_q.v0 & rx_ready;
    if (pop) begin
      r_d.buf0 = r_q.buf1;
      r_d.v0   = r_q.v1;
      r_d.v1   = 1'b0;
    end
    if (push) begin
      if (~r_d.v0) begin
        r_d.buf0 = entry;
        r_d.v0   = 1'b1;
      end else if (~r_d.v1) begin
        r_d.buf1 = entry;
        r_d.v1   = 1'b1;
      end else begin
        r_d.overrun = 1'b1;
      end
    end

    r_d.lane_oe = (r_d.st == ST_DRIVE && cs_low && !paused) ? lane_oe_of(lane_mode) : 4'h0;
    if (r_d.st != ST_DRIVE) begin
      r_d.lane_o = 4'h0;
    end
    r_d.frame   = (r_d.st == ST_RX || r_d.st == ST_DUMMY || r_d.st == ST_DRIVE);
    r_d.dev_rst = (r_d.st == ST_RST_HOLD || r_d.st == ST_RECOVER);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_q         <= '0;
      r_q.lane_s1 <= LANE_SYNC_RST;
      r_q.lane_s2 <= LANE_SYNC_RST;
      r_q.sw_ok   <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign io_lane_0_out   = r_q.lane_o[0];
  assign io_lane_1_out   = r_q.lane_o[1];
  assign io_lane_2_out   = r_q.lane_o[2];
  assign io_lane_3_out   = r_q.lane_o[3];
  assign io_lane_0_oe    = r_q.lane_oe[0];
  assign io_lane_1_oe    = r_q.lane_oe[1];
  assign io_lane_2_oe    = r_q.lane_oe[2];
  assign io_lane_3_oe    = r_q.lane_oe[3];
  assign rx_data         = r_q.buf0[7:0];
  assign rx_page_over    = r_q.buf0[8];
  assign rx_first        = r_q.buf0[9];
  assign rx_valid        = r_q.v0;
  assign rx_overrun      = r_q.overrun;
  assign tx_ready        = r_q.tx_rdy;
  assign frame_active    = r_q.frame;
  assign device_reset    = r_q.dev_rst;
  assign status_write_ok = r_q.sw_ok;
  assign array_guarded   = r_q.guarded;

endmodule

// [sim/sfpf_front_end_assertions.sv]
// Port-level checks of the serial flash front end
`timescale 1ns/1ps
module sfpf_checker
  import sfpf_pkg::*;
#(
  parameter int RECOVERY_CYC = RESET_RECOVERY_CYC
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       chip_sel_n,
  input wire logic       io_lane_2_in,
  input wire logic       io_lane_3_in,
  input wire logic       io_lane_0_oe,
  input wire logic       io_lane_1_oe,
  input wire logic       io_lane_2_oe,
  input wire logic       io_lane_3_oe,
  input wire sfpf_lane_t lane_mode,
  input wire logic       pin_function_disable,
  input wire logic       pause_or_reset_select,
  input wire logic       status_reg_lock,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       frame_active,
  input wire logic       device_reset,
  input wire logic       status_write_ok
);
  // ----------------------------------------
  // Shared pin level run lengths
  // ----------------------------------------
  logic [15:0] low_q;
  logic [15:0] high_q;
  logic [3:0]  oe;
  assign oe = {io_lane_3_oe, io_lane_2_oe, io_lane_1_oe, io_lane_0_oe};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_q  <= 16'h0;
      high_q <= 16'h0;
    end else begin
      low_q  <= io_lane_3_in ? 16'h0 : low_q + 16'h1;
      high_q <= io_lane_3_in ? high_q + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence desel_s;
    chip_sel_n [*6];
  endsequence
  sequence wp_low_s;
    (status_reg_lock && !io_lane_2_in && lane_mode != LANE_QUAD) [*4];
  endsequence
  desel_float_a: assert property (desel_s |-> oe == 4'h0)
    else $error("lane driven while deselected");
  desel_idle_a: assert property (desel_s |-> !frame_active)
    else $error("frame active while deselected");
  single_lanes_a: assert property (lane_mode == LANE_SINGLE && $past(lane_mode) == LANE_SINGLE |-> (oe & 4'hD) == 4'h0)
    else $error("single mode drives a lane other than lane 1");
  dual_lanes_a: assert property (lane_mode == LANE_DUAL && $past(lane_mode) == LANE_DUAL |-> (oe & 4'hC) == 4'h0)
    else $error("dual mode drives lane 2 or 3");
  reset_cause_a: assert property ($rose(device_reset) |-> $past(!pin_function_disable && pause_or_reset_select && lane_mode != LANE_QUAD))
    else $error("reset without enabled reset pin");
  reset_pulse_a: assert property ($rose(device_reset) |-> low_q >= RESET_PULSE_MIN_CYC)
    else $error("reset pulse shorter than minimum");
  reset_quiet_a: assert property (device_reset && $past(device_reset) |-> oe == 4'h0 && !frame_active)
    else $error("activity during reset");
  recover_len_a: assert property ($fell(device_reset) |-> high_q > RECOVERY_CYC)
    else $error("recovery too short");
  recover_end_a: assert property (high_q == RECOVERY_CYC + 12 |-> !device_reset)
    else $error("recovery too long");
  wp_block_a: assert property (wp_low_s |-> !status_write_ok)
    else $error("status write allowed while protected");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte lost before pop");
endmodule
bind sfpf_front_end sfpf_checker #(.RECOVERY_CYC(RECOVERY_CYC)) chk_u (
  .clk_sys, .rst, .chip_sel_n, .io_lane_2_in, .io_lane_3_in,
  .io_lane_0_oe, .io_lane_1_oe, .io_lane_2_oe, .io_lane_3_oe,
  .lane_mode, .pin_function_disable, .pause_or_reset_select, .status_reg_lock,
  .rx_data, .rx_valid, .rx_ready, .frame_active, .device_reset, .status_write_ok);

// [sim/sfpf_host_model.sv]
// Host controller model: serial clock, select and lane levels
`timescale 1ns/1ps
module sfpf_host_model (
  input  wire logic [3:0] dut_out,
  input  wire logic [3:0] dut_oe,
  output logic            serial_clk,
  output logic            chip_sel_n,
  output logic [3:0]      pin
);
  logic [3:0] hv = 4'hF;
  logic [3:0] hoe = 4'hC;
  logic [1:0] side_q = 2'h3;
  logic       flip = 1'h0;
  initial serial_clk = 1'h0;
  initial chip_sel_n = 1'h1;
  // Released lanes toggle so a stale level never passes for data
  always #4 flip = ~flip;
  assign pin = (dut_oe & dut_out) | (~dut_oe & hoe & hv) | (~dut_oe & ~hoe & {4{flip}});
  // select falls with clock at its idle level
  task automatic start(input logic cpol);
    serial_clk = cpol;
    #20 chip_sel_n = 1'h0;
    #20;
  endtask
  task automatic stop();
    #16 chip_sel_n = 1'h1;
    hoe = 4'hC;
    hv[3:2] = side_q;
    #40;
  endtask
  // side levels on lanes 2 and 3
  task automatic side(input logic wp_n, input logic ctl_n);
    side_q = {ctl_n, wp_n};
    hv[3:2] = side_q;
  endtask
  // MSB first, drive while clock low, sample mid-high
  task automatic shift(input int w, input logic rd, input logic [7:0] tx, output logic [7:0] rx);
    int j;
    rx = 8'h0;
    hoe = (w == 4) ? {4{!rd}} : (w == 2) ? {2'h3, {2{!rd}}} : 4'hD;
    repeat (8 / w) begin
      serial_clk = 1'h0;
      for (j = 0; j < w; j++) hv[j] = tx[8 - w + j];
      tx = tx << w;
      #16 serial_clk = 1'h1;
      #8 rx = rx << w;
      for (j = 0; j < w; j++) rx[j] = (w == 1) ? pin[1] : pin[j];
      #8;
    end
  endtask
endmodule

// [sim/serial_flash_pin_front_end_test.sv]
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
module serial_flash_pin_front_end_test
  import sfpf_pkg::*;
();
  localparam int REC = 20;
  logic clk_sys = 1'h0, rst = 1'h1, serial_clk, chip_sel_n;
  logic [3:0] pin, dout, doe, block_guard_bits = 4'h0;
  sfpf_lane_t lane_mode = LANE_SINGLE;
  logic pin_function_disable = 1'h0, pause_or_reset_select = 1'h0, status_reg_lock = 1'h0;
  logic dummy_cfg_en = 1'h0, page_program_active = 1'h0, turnaround_req = 1'h0;
  logic rx_ready = 1'h0, tx_valid = 1'h1, rx_page_over, rx_valid, rx_overrun, rx_first, tx_ready;
  logic frame_active, device_reset, status_write_ok, array_guarded;
  logic [1:0] dummy_cfg = 2'h2;
  logic [7:0] tx_data = 8'h00, rx_data, got;
  logic [4:0] rt [5] = '{5'h01, 5'h02, 5'h10, 5'h0C, 5'h09};
  logic [5:0] wt [5] = '{6'h05, 6'h0E, 6'h26, 6'h12, 6'h15};
  int fails = 0, checks_done = 0, tx_taken = 0, k, i, w;
  always #2 clk_sys = ~clk_sys;
  sfpf_front_end #(.RECOVERY_CYC(REC)) dut_u (
    .clk_sys, .rst, .serial_clk, .chip_sel_n,
    .io_lane_0_in(pin[0]), .io_lane_0_out(dout[0]), .io_lane_0_oe(doe[0]),
    .io_lane_1_in(pin[1]), .io_lane_1_out(dout[1]), .io_lane_1_oe(doe[1]),
    .io_lane_2_in(pin[2]), .io_lane_2_out(dout[2]), .io_lane_2_oe(doe[2]),
    .io_lane_3_in(pin[3]), .io_lane_3_out(dout[3]), .io_lane_3_oe(doe[3]),
    .lane_mode, .pin_function_disable, .pause_or_reset_select, .status_reg_lock,
    .block_guard_bits, .dummy_cfg_en, .dummy_cfg, .page_program_active, .turnaround_req,
    .rx_data, .rx_first, .rx_page_over, .rx_valid, .rx_ready, .rx_overrun,
    .tx_data, .tx_valid, .tx_ready, .frame_active, .device_reset, .status_write_ok,
    .array_guarded);
  sfpf_host_model host_u (.dut_out(dout), .dut_oe(doe), .serial_clk, .chip_sel_n, .pin);
  // Every byte handed to the link shows as one ready pulse
  always @(posedge clk_sys) begin
    if (tx_ready === 1'h1) tx_taken <= tx_taken + 1;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pop(input logic [7:0] exp, input logic over);
    int n;
    n = 0;
    tick(1);
    while (rx_valid !== 1'h1 && n < 500) begin
      tick(1);
      n++;
    end
    chk(rx_valid, 1'h1);
    chk(rx_data, exp);
    chk(rx_page_over, over);
    rx_ready = 1'h1;
    tick(1);
    rx_ready = 1'h0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    tick(16);
    rst = 1'h0;
    tick(8);
    // Third byte with a stalled reader must be flagged lost
    host_u.start(1'h0);
    for (i = 0; i < 3; i++) host_u.shift(1, 1'h0, 8'(8'hA5 + i), got);
    host_u.stop();
    chk(rx_overrun, 1'h1);
    chk(rx_first, 1'h1);
    pop(8'hA5, 1'h0);
    chk(rx_first, 1'h0);
    pop(8'hA6, 1'h0);
    chk(rx_valid, 1'h0);
    // Command then fast read in each lane mode, one row in clock mode 3, last with no dummy
    for (k = 0; k < 5; k++) begin
      lane_mode = sfpf_lane_t'((k == 3) ? 1 : (k == 4) ? 0 : k);
      w = 1 << int'(lane_mode);
      dummy_cfg_en = (k >= 3);
      dummy_cfg = (k == 4) ? 2'h0 : 2'h2;
      tx_data = 8'(8'hC3 ^ k);
      host_u.start(k == 1);
      chk(frame_active, 1'h1);
      chk(rx_overrun, 1'h0);
      host_u.shift(w, 1'h0, 8'(8'h3B + k), got);
      pop(8'(8'h3B + k), 1'h0);
      turnaround_req = 1'h1;
      tick(1);
      turnaround_req = 1'h0;
      repeat (dummy_cfg_en ? int'(dummy_cfg) : (w == 4) ? 3 : 1) host_u.shift(w, 1'h1, 8'h00, got);
      host_u.shift(w, 1'h1, 8'h00, got);
      chk(got, tx_data);
      host_u.stop();
      chk(doe, 4'h0);
      chk(8'(tx_taken), 8'(k + 1));
    end
    dummy_cfg_en = 1'h0;
    lane_mode = LANE_SINGLE;
    // Pause hides the middle byte unless the pin function is off
    for (k = 0; k < 2; k++) begin
      pin_function_disable = k[0];
      host_u.start(1'h0);
      host_u.shift(1, 1'h0, 8'h11, got);
      pop(8'h11, 1'h0);
      host_u.side(1'h1, 1'h0);
      host_u.shift(1, 1'h0, 8'h22, got);
      host_u.side(1'h1, 1'h1);
      host_u.shift(1, 1'h0, 8'h33, got);
      host_u.stop();
      if (k == 1) pop(8'h22, 1'h0);
      pop(8'h33, 1'h0);
      chk(rx_valid, 1'h0);
    end
    // Reset pin: mode, disable, short pulse and expected reset per row
    pause_or_reset_select = 1'h1;
    for (k = 0; k < 5; k++) begin
      lane_mode = sfpf_lane_t'(rt[k][4:3]);
      pin_function_disable = rt[k][2];
      host_u.side(1'h1, 1'h0);
      tick(rt[k][1] ? 100 : 300);
      chk(device_reset, rt[k][0]);
      host_u.side(1'h1, 1'h1);
      tick(5);
      chk(device_reset, rt[k][0]);
      chk(doe, 4'h0);
      tick(REC + 20);
      chk(device_reset, 1'h0);
    end
    pause_or_reset_select = 1'h0;
    pin_function_disable = 1'h0;
    // Write protect: mode, protect level, lock, expected write and guard
    block_guard_bits = 4'h4;
    for (k = 0; k < 5; k++) begin
      lane_mode = sfpf_lane_t'(wt[k][5:4]);
      status_reg_lock = wt[k][2];
      host_u.side(wt[k][3], 1'h1);
      tick(8);
      chk(status_write_ok, wt[k][1]);
      chk(array_guarded, wt[k][0]);
    end
    host_u.side(1'h1, 1'h1);
    // Page program: command plus 257 data bytes, last one over the page
    lane_mode = LANE_QUAD;
    page_program_active = 1'h1;
    host_u.start(1'h0);
    for (i = 0; i < 258; i++) begin
      host_u.shift(4, 1'h0, 8'(i), got);
      pop(8'(i), i == 257);
    end
    host_u.stop();
    report_and_stop();
  end
  // Full run is near 31 us; wide margin before giving up
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
